// [design/tmc_core.sv]
// Thermal monitor core: conversion schedule, alarm logic and bus target
//
// Overview of operation
// [RULE1] Normal mode starts a conversion each period and stores each result.
// [RULE2] Conversion takes about 28 ms; converter idles for rest of period.
// [RULE3] Result held as 11-bit two's complement, 0.125 degree per step.
// [RULE4] Bus reads never disturb or delay a running conversion.
// [RULE5] Shutdown stops conversions, keeps the result, bus stays usable.
// [RULE6] Configuration bit 0 selects normal or shutdown.
// [RULE7] Conversion starts at power-up and on leaving shutdown.
// [RULE8] Each normal-mode result is compared against both thresholds.
// [RULE9] Thresholds are 9-bit two's complement, compared with top 9 result bits.
// [RULE10] Host keeps overtemperature threshold above hysteresis threshold.
// [RULE11] Bit 1 picks comparator or interrupt alarm; bits 3-4 hold fault queue.
// [RULE12] Comparator alarm sets above overtemperature, clears below hysteresis.
// [RULE13] Comparator alarm unaffected by register reads or shutdown.
// [RULE14] Interrupt alarm first trips on overtemperature, holds until any read.
// [RULE15] Interrupt trip condition alternates overtemperature and hysteresis.
// [RULE16] Entering shutdown clears an asserted interrupt alarm.
// [RULE17] Alarm trips only after the programmed consecutive fault count.
// [RULE18] Configuration bit 2 selects alarm active level.
// [RULE19] Reset: normal, comparator, 80 and 75 degrees, active low, one fault.
// [RULE20] Result reads zero after reset until first conversion ends.
// [RULE21] SDA held low past time-out returns bus logic to idle, SDA released.
// [RULE22] Host drives the bus clock; the device only acts as target.
// [RULE23] Pointer low three bits select register; upper bits are zero.
// [RULE24] Address select pins sampled once after reset, then held.
// [RULE25] Fault counter counts consecutive matches, clears on any miss.
// [RULE26] Queue code to fault count mapping is a parameter; reset means one.
`timescale 1ns/1ps
`default_nettype none
module tmc_core
   import tmc_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = CONV_PERIOD_CYC,
   parameter int unsigned CONV_CYC = CONV_TIME_CYC,
   parameter int unsigned TIMEOUT_CYC = BUS_TO_CYC,
   parameter int unsigned STEP_CYC = IDLE_STEP_CYC,
   parameter logic [11:0] FAULT_MAP = FAULT_MAP_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus clock from the host
   input wire logic scl,
   // Bus data line, open drain
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address select pins
   input wire logic addr_select_pin_0,
   input wire logic addr_select_pin_1,
   input wire logic addr_select_pin_2,
   // Converter front end
   output logic conv_busy,
   input wire logic [10:0] adc_code,
   // Alarm pin, open drain
   output logic thermal_alarm_output,
   output logic thermal_alarm_output_oe
);
   localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

   logic [4:0] sync1_q, sync2_q;
   logic scl_s, sda_s, scl_d_q, sda_d_q;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   logic [1:0] pwr_q;
   logic addr_done_q;
   logic [6:0] addr_q;
   logic [7:0] rx_shift_q;
   tmc_bus_st_t st_q;
   logic [3:0] bit_cnt_q;
   logic [1:0] byte_cnt_q;
   logic rw_q, lo_sel_q, oe_q;
   logic [2:0] ptr_q;
   logic [7:0] tx_q;
   logic [TO_W-1:0] to_cnt_q;
   logic to_hit, byte_end, addr_ok, rd_clr, wr_fire;
   logic [15:0] rd_word;
   logic [7:0] rd_byte;
   logic is_word;
   tmc_cfg_t cfg_q;
   logic [8:0] hyst_q, over_q;
   logic [7:0] idle_q;
   logic [31:0] per_cnt_q, per_next, period_len;
   logic conv_busy_q, done_q;
   logic [10:0] temp_q;
   logic sd_d_q, sd_rise;
   logic signed [8:0] temp9;
   logic over_hit, under_hit, hunt_low, cond, trip;
   logic [2:0] fcnt_q, fcnt_next, fault_need;
   logic alarm_q, arm_low_q, os_oe_q;

   // Pin synchronisers; only the second stage is read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 5'h1f;
         sync2_q <= 5'h1f;
      end else begin
         sync1_q <= {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, sda_in, scl};
         sync2_q <= sync1_q;
      end
   end
   assign scl_s = sync2_q[0];
   assign sda_s = sync2_q[1];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end
   assign scl_rise = scl_s & ~scl_d_q;
   assign scl_fall = ~scl_s & scl_d_q;
   assign start_ev = scl_s & scl_d_q & sda_d_q & ~sda_s;
   assign stop_ev = scl_s & scl_d_q & ~sda_d_q & sda_s;

   // [RULE24] One-time address capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_q <= 2'h0;
         addr_done_q <= 1'b0;
         addr_q <= ADDR_BASE;
      end else begin
         pwr_q <= {pwr_q[0], 1'b1};
         if (pwr_q[1] && !addr_done_q) begin
            addr_done_q <= 1'b1;
            addr_q <= ADDR_BASE | {4'h0, sync2_q[4:2]};
         end
      end
   end

   // [RULE22] Receive shifter on the host's bus clock
   always_ff @(posedge scl or negedge rst_b) begin
      if (!rst_b) begin
         rx_shift_q <= 8'h00;
      end else begin
         rx_shift_q <= {rx_shift_q[6:0], sda_in};
      end
   end

   // Shifter is read only after the synced falling edge, while it is stable
   assign byte_end = (st_q == ST_RXB) && scl_fall && (bit_cnt_q == 4'h8);
   assign addr_ok = rx_shift_q[7:1] == addr_q;
   assign rd_clr = byte_end && (byte_cnt_q == 2'h0) && addr_ok && rx_shift_q[0];
   assign wr_fire = byte_end && (byte_cnt_q == 2'h2);

   // [RULE21] Stuck-low time-out counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         to_cnt_q <= '0;
      end else if (sda_s) begin
         to_cnt_q <= '0;
      end else if (!to_hit) begin
         to_cnt_q <= to_cnt_q + TO_W'(1);
      end
   end
   assign to_hit = to_cnt_q == TO_W'(TIMEOUT_CYC);

   // [RULE23] Register read selection
   always_comb begin
      rd_word = 16'h0000;
      is_word = 1'b1;
      case (ptr_q)
         PTR_TEMP: rd_word = {temp_q, 5'h00};
         PTR_HYST: rd_word = {hyst_q, 7'h00};
         PTR_OVER: rd_word = {over_q, 7'h00};
         PTR_CONF: begin
            rd_word = {cfg_q, 8'h00};
            is_word = 1'b0;
         end
         PTR_IDLE: begin
            rd_word = {idle_q, 8'h00};
            is_word = 1'b0;
         end
         default: rd_word = 16'h0000;
      endcase
      rd_byte = (lo_sel_q && is_word) ? rd_word[7:0] : rd_word[15:8];
   end

   // Bus target sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         byte_cnt_q <= 2'h0;
         rw_q <= 1'b0;
         lo_sel_q <= 1'b0;
         oe_q <= 1'b0;
         ptr_q <= PTR_TEMP;
         tx_q <= 8'h00;
      // [RULE21] Time-out or stop releases the line
      end else if (to_hit || stop_ev) begin
         st_q <= ST_IDLE;
         oe_q <= 1'b0;
      end else if (start_ev) begin
         st_q <= ST_RXB;
         bit_cnt_q <= 4'h0;
         byte_cnt_q <= 2'h0;
         oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: oe_q <= 1'b0;
            ST_RXB: begin
               if (scl_rise) bit_cnt_q <= bit_cnt_q + 4'h1;
               if (byte_end) begin
                  bit_cnt_q <= 4'h0;
                  if (byte_cnt_q == 2'h0 && !addr_ok) begin
                     st_q <= ST_IDLE;
                  end else begin
                     st_q <= ST_ACK;
                     oe_q <= 1'b1;
                     if (byte_cnt_q != 2'h2) byte_cnt_q <= byte_cnt_q + 2'h1;
                     if (byte_cnt_q == 2'h0) begin
                        rw_q <= rx_shift_q[0];
                        lo_sel_q <= 1'b0;
                     end
                     // [RULE23] Pointer keeps low three bits
                     if (byte_cnt_q == 2'h1) begin
                        ptr_q <= rx_shift_q[2:0];
                        lo_sel_q <= 1'b0;
                     end
                     if (byte_cnt_q == 2'h2) lo_sel_q <= ~lo_sel_q;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall && rw_q) begin
                  st_q <= ST_TXB;
                  tx_q <= rd_byte;
                  oe_q <= ~rd_byte[7];
                  lo_sel_q <= ~lo_sel_q;
                  bit_cnt_q <= 4'h1;
               end else if (scl_fall) begin
                  st_q <= ST_RXB;
                  oe_q <= 1'b0;
               end
            end
            ST_TXB: begin
               if (scl_fall && bit_cnt_q == 4'h8) begin
                  st_q <= ST_RACK;
                  oe_q <= 1'b0;
               end else if (scl_fall) begin
                  tx_q <= {tx_q[6:0], 1'b0};
                  oe_q <= ~tx_q[6];
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
            end
            ST_RACK: begin
               if (scl_rise && sda_s) begin
                  st_q <= ST_IDLE;
               end else if (scl_fall) begin
                  st_q <= ST_TXB;
                  tx_q <= rd_byte;
                  oe_q <= ~rd_byte[7];
                  lo_sel_q <= ~lo_sel_q;
                  bit_cnt_q <= 4'h1;
               end
            end
         endcase
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = oe_q;

   // [RULE19] Register writes and power-up defaults
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= tmc_cfg_t'(CONF_RST);
         hyst_q <= HYST_RST;
         over_q <= OVER_RST;
         idle_q <= IDLE_RST;
      end else if (wr_fire) begin
         unique case (ptr_q)
            // [RULE6] Mode, alarm and queue bits
            PTR_CONF: cfg_q <= tmc_cfg_t'(rx_shift_q);
            // [RULE9] Nine-bit thresholds, high byte first
            PTR_HYST: begin
               if (lo_sel_q) hyst_q[0] <= rx_shift_q[7];
               else hyst_q[8:1] <= rx_shift_q;
            end
            PTR_OVER: begin
               if (lo_sel_q) over_q[0] <= rx_shift_q[7];
               else over_q[8:1] <= rx_shift_q;
            end
            PTR_IDLE: idle_q <= rx_shift_q;
            default: idle_q <= idle_q;
         endcase
      end
   end

   // [RULE1] Period length, idle code zero means default period
   assign period_len = (idle_q == 8'h00) ? PERIOD_CYC
                     : 32'(idle_q) * STEP_CYC + CONV_CYC;
   assign per_next = (per_cnt_q >= period_len - 32'h1) ? 32'h0 : per_cnt_q + 32'h1;

   // [RULE4] Scheduler sees no bus activity, only configuration
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         per_cnt_q <= 32'h0;
         // [RULE7] First conversion starts out of reset
         conv_busy_q <= 1'b1;
         done_q <= 1'b0;
         // [RULE20] Result reads zero until first conversion
         temp_q <= TEMP_RST;
      // [RULE5] Shutdown halts converter, keeps result
      end else if (cfg_q.shutdown) begin
         per_cnt_q <= 32'h0;
         conv_busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         // [RULE2] Busy only for the conversion time
         per_cnt_q <= per_next;
         conv_busy_q <= per_next < CONV_CYC;
         done_q <= per_cnt_q == CONV_CYC - 1;
         // [RULE3] Eleven-bit result captured at end of conversion
         if (per_cnt_q == CONV_CYC - 1) temp_q <= adc_code;
      end
   end
   assign conv_busy = conv_busy_q;

   // [RULE9] Compare the upper nine result bits
   assign temp9 = $signed(temp_q[10:2]);
   assign over_hit = temp9 > $signed(over_q);
   assign under_hit = temp9 < $signed(hyst_q);

   // [RULE26] Fault count from queue code
   always_comb begin
      unique case (cfg_q.fault_q)
         2'h0: fault_need = FAULT_MAP[2:0];
         2'h1: fault_need = FAULT_MAP[5:3];
         2'h2: fault_need = FAULT_MAP[8:6];
         2'h3: fault_need = FAULT_MAP[11:9];
      endcase
   end

   // [RULE11] Behaviour chooses which condition is hunted
   assign hunt_low = cfg_q.int_mode ? arm_low_q : alarm_q;
   assign cond = hunt_low ? under_hit : over_hit;
   assign fcnt_next = fcnt_q + 3'h1;
   // [RULE17] Trip after enough consecutive faults
   assign trip = done_q && cond && (fcnt_next >= fault_need)
               && !(cfg_q.int_mode && alarm_q);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) sd_d_q <= 1'b0;
      else sd_d_q <= cfg_q.shutdown;
   end
   assign sd_rise = cfg_q.shutdown && !sd_d_q;

   // [RULE25] Consecutive fault counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fcnt_q <= 3'h0;
      end else if (done_q) begin
         if (!cond || trip) fcnt_q <= 3'h0;
         else if (fcnt_next < fault_need) fcnt_q <= fcnt_next;
      end
   end

   // [RULE8] Alarm update after each normal-mode result
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm_q <= 1'b0;
         arm_low_q <= 1'b0;
      end else if (!cfg_q.int_mode) begin
         // [RULE12] Thermostat toggle with hysteresis
         if (trip) alarm_q <= ~alarm_q;
         arm_low_q <= 1'b0;
      // [RULE15] Interrupt trip alternates, set wins over clear
      end else if (trip) begin
         alarm_q <= 1'b1;
         arm_low_q <= ~arm_low_q;
      // [RULE14] Any read clears; [RULE16] entering shutdown clears
      end else if (rd_clr || sd_rise) begin
         alarm_q <= 1'b0;
      end
   end

   // [RULE18] Active level select on open-drain pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) os_oe_q <= 1'b0;
      else os_oe_q <= alarm_q ^ cfg_q.pol_high;
   end
   assign thermal_alarm_output = 1'b0;
   assign thermal_alarm_output_oe = os_oe_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_temp_capture: assert property (done_q |-> temp_q == $past(adc_code)) // [RULE1]
      else $error("result not taken from converter");
   a_busy_window: assert property (conv_busy_q |-> per_cnt_q < CONV_CYC) // [RULE2]
      else $error("converter busy past conversion time");
   a_shutdown_hold: assert property (cfg_q.shutdown ##1 cfg_q.shutdown |-> $stable(temp_q)) // [RULE5]
      else $error("result changed in shutdown");
   a_comp_trip: assert property (done_q && !cfg_q.int_mode && !alarm_q && over_hit // [RULE12]
         && fault_need == 3'h1 |=> alarm_q)
      else $error("comparator alarm missed overtemperature");
   a_comp_steady: assert property (!cfg_q.int_mode && !done_q |=> $stable(alarm_q)) // [RULE13]
      else $error("comparator alarm moved without a result");
   a_int_hold: assert property (cfg_q.int_mode && alarm_q && !rd_clr && !sd_rise // [RULE14]
         |=> alarm_q)
      else $error("interrupt alarm dropped without clear");
   a_int_alternate: assert property (cfg_q.int_mode && trip |=> arm_low_q != $past(arm_low_q)) // [RULE15]
      else $error("trip condition did not alternate");
   a_int_sd_clear: assert property (cfg_q.int_mode && sd_rise && !trip |=> !alarm_q) // [RULE16]
      else $error("shutdown did not clear interrupt alarm");
   a_fault_cause: assert property ($rose(alarm_q) |-> $past(done_q)) // [RULE17]
      else $error("alarm rose without a conversion");
   a_pol_low: assert property (alarm_q && !cfg_q.pol_high ##1 alarm_q && !cfg_q.pol_high // [RULE18]
         |-> thermal_alarm_output_oe)
      else $error("active-low alarm not driven");
   a_timeout_idle: assert property (to_hit |=> st_q == ST_IDLE && !sda_oe) // [RULE21]
      else $error("time-out did not release bus");
   a_addr_held: assert property (addr_done_q |=> $stable(addr_q)) // [RULE24]
      else $error("target address changed after capture");

   c_comp_alarm: cover property (!cfg_q.int_mode && $rose(alarm_q));
   c_read_clear: cover property (cfg_q.int_mode && alarm_q ##1 rd_clr ##1 !alarm_q);
   c_timeout: cover property (to_hit && st_q != ST_IDLE);
   c_reg_write: cover property (wr_fire && ptr_q == PTR_OVER);
endmodule : tmc_core
`default_nettype wire

// [design/tmc_pkg.sv]
// Shared constants and types of the thermal monitor core
`default_nettype none
package tmc_pkg;
   // Timing base and documented times
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned CONV_PERIOD_MS = 100;
   localparam int unsigned CONV_TIME_MS = 28;
   localparam int unsigned BUS_TO_MIN_MS = 25;
   localparam int unsigned IDLE_STEP_MS = 10;
   localparam int unsigned CONV_PERIOD_CYC = CLK_HZ / 1000 * CONV_PERIOD_MS;
   localparam int unsigned CONV_TIME_CYC = CLK_HZ / 1000 * CONV_TIME_MS;
   localparam int unsigned BUS_TO_CYC = (CLK_HZ / 1000 * BUS_TO_MIN_MS + 999) / 1000 * 1000;
   localparam int unsigned IDLE_STEP_CYC = CLK_HZ / 1000 * IDLE_STEP_MS;

   // Register pointer values
   localparam logic [2:0] PTR_TEMP = 3'h0;
   localparam logic [2:0] PTR_CONF = 3'h1;
   localparam logic [2:0] PTR_HYST = 3'h2;
   localparam logic [2:0] PTR_OVER = 3'h3;
   localparam logic [2:0] PTR_IDLE = 3'h4;

   // Reset values: 80 and 75 degrees in half-degree steps
   localparam logic [8:0] OVER_RST = 9'h0a0;
   localparam logic [8:0] HYST_RST = 9'h096;
   localparam logic [7:0] CONF_RST = 8'h00;
   localparam logic [7:0] IDLE_RST = 8'h00;
   localparam logic [10:0] TEMP_RST = 11'h000;

   // Target address base, low three bits from the select pins
   localparam logic [6:0] ADDR_BASE = 7'h48;

   // Fault counts for queue codes 3..0, three bits each
   localparam logic [11:0] FAULT_MAP_DEF = 12'hd11;

   // Configuration byte layout
   typedef struct packed {
      logic [2:0] spare;
      logic [1:0] fault_q;
      logic pol_high;
      logic int_mode;
      logic shutdown;
   } tmc_cfg_t;

   // Bus target states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RXB = 5'b00010,
      ST_ACK = 5'b00100,
      ST_TXB = 5'b01000,
      ST_RACK = 5'b10000
   } tmc_bus_st_t;
endpackage : tmc_pkg
`default_nettype wire

// [verification/tmc_host_model.sv]
// Bus host model for the target interface of the core
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
   // Host base clock
   input wire logic lclk,
   // Bus wires
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic ph();
      repeat (4) @(posedge lclk);
   endtask : ph
   task automatic bitx(input logic d, output logic r);
      @(posedge lclk);
      sda_pull <= !d;
      ph();
      scl <= 1'b1;
      ph();
      r = sda;
      scl <= 1'b0;
   endtask : bitx
   // Data edge while clock high: start or stop
   task automatic seq(input logic s0, input logic s1);
      @(posedge lclk);
      sda_pull <= s0;
      ph();
      scl <= 1'b1;
      ph();
      sda_pull <= s1;
      ph();
   endtask : seq
   task automatic start();
      seq(1'b0, 1'b1);
      scl <= 1'b0;
   endtask : start
   task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r[i]);
      end
      bitx(b9, a);
   endtask : xfer
   task automatic xact(input logic [6:0] ad, input logic [2:0] p, input logic rd, input int n,
                       input logic [15:0] wv, output logic [15:0] rv, output logic nak);
      logic [7:0] r;
      logic a;
      rv = 16'h0000;
      start();
      xfer({ad, 1'b0}, 1'b1, r, nak);
      xfer({5'h00, p}, 1'b1, r, a);
      if (rd) begin
         start();
         xfer({ad, 1'b1}, 1'b1, r, a);
      end
      for (int i = n - 1; i >= 0; i--) begin
         xfer(rd ? 8'hff : wv[8*i+:8], !rd || i == 0, r, a);
         rv = {rv[7:0], r};
      end
      seq(1'b1, 1'b0);
   endtask : xact
   // Address byte, then clock left low
   task automatic stuck(input logic [6:0] ad);
      logic r;
      start();
      for (int i = 6; i >= 0; i--) begin
         bitx(ad[i], r);
      end
      bitx(1'b0, r);
      @(posedge lclk);
      sda_pull <= 1'b0;
   endtask : stuck
endmodule : tmc_host_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench of the thermal monitor core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) begin \
         err_count++; \
         $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
      end \
   end
module tb;
   import tmc_pkg::*;
   // Time-out well above the longest low run of SDA within a transfer
   localparam int unsigned PER = 200, CONV = 50, TO = 500, STEP = 20;
   logic clk, lclk, rst_b, scl, sda, sda_out, sda_oe, pull, busy, alarm, alarm_oe, nak, b, pol;
   logic [2:0] pins;
   logic [6:0] addr;
   logic [8:0] ov, hy;
   logic [10:0] adc, a, hot, mid, cold;
   logic [15:0] v;
   int err_count, cmp_count, cyc, n;
   // Pull-up on the shared data wire
   assign sda = !(sda_oe | pull);
   always @(posedge clk) cyc <= cyc + 1;
   tmc_host_model h (.lclk(lclk), .sda(sda), .scl(scl), .sda_pull(pull));
   tmc_core #(.PERIOD_CYC(PER), .CONV_CYC(CONV), .TIMEOUT_CYC(TO), .STEP_CYC(STEP)) DUT (
      .clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin_0(pins[0]), .addr_select_pin_1(pins[1]), .addr_select_pin_2(pins[2]),
      .conv_busy(busy), .adc_code(adc), .thermal_alarm_output(alarm),
      .thermal_alarm_output_oe(alarm_oe)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever #32 lclk = ~lclk;
   end
   function automatic logic exp_oe(input logic act);
      return act ^ pol;
   endfunction : exp_oe
   function automatic int fault_n(input int q);
      return (q == 0) ? 1 : q * 2;
   endfunction : fault_n
   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [2:0] p, input logic [15:0] d, input int k);
      h.xact(addr, p, 1'b0, k, d, v, nak);
   endtask : wr
   task automatic rd(input logic [2:0] p, input int k);
      h.xact(addr, p, 1'b1, k, 16'h0000, v, nak);
   endtask : rd
   task automatic wait_lvl(input logic l);
      int t;
      t = 0;
      while (busy !== l && t < 2000) begin
         @(negedge clk);
         t++;
      end
      if (t >= 2000) begin
         err_count++;
         print_verdict();
      end
   endtask : wait_lvl
   task automatic conv(input int k);
      repeat (k) begin
         wait_lvl(1'b1);
         wait_lvl(1'b0);
      end
      repeat (6) @(negedge clk);
   endtask : conv
   task automatic set_adc(input logic [10:0] d);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      @(posedge clk);
      adc <= d;
   endtask : set_adc
   task automatic meas(input int exp_per);
      int t0;
      int w;
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      t0 = cyc;
      wait_lvl(1'b0);
      w = cyc - t0;
      wait_lvl(1'b1);
      `CHK("period", exp_per, cyc - t0)
      `CHK("busy_len", 1'b1, (w >= CONV - 1 && w <= CONV))
   endtask : meas
   initial begin
      v = 16'($urandom(96));
      rst_b = 1'b0;
      pol = 1'b0;
      adc = 11'h000;
      pins = 3'($urandom);
      addr = ADDR_BASE | {4'h0, pins};
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
      pins <= ~pins;
      rd(PTR_CONF, 1);
      `CHK("conf_rst", 16'h0000, v)
      `CHK("addr_ack", 1'b0, nak)
      rd(PTR_OVER, 2);
      `CHK("over_rst", 16'h5000, v)
      rd(PTR_HYST, 2);
      `CHK("hyst_rst", 16'h4b00, v)
      `CHK("alarm_rst", exp_oe(1'b0), alarm_oe)
      `CHK("pin_lvl", 2'b00, {alarm, sda_out})
      h.xact(ADDR_BASE | {4'h0, ~addr[2:0]}, PTR_CONF, 1'b0, 1, 16'h0001, v, nak);
      `CHK("addr_nak", 1'b1, nak)
      a = {1'b1, 10'($urandom)};
      set_adc(a);
      conv(1);
      fork
         meas(PER);
         rd(PTR_TEMP, 2);
      join
      `CHK("temp", {a, 5'h00}, v)
      wr(PTR_IDLE, 16'h0002, 1);
      meas(2 * STEP + CONV);
      rd(PTR_IDLE, 1);
      `CHK("idle_rd", 16'h0002, v)
      wr(PTR_IDLE, 16'h0000, 1);
      wr(PTR_CONF, 16'h0001, 1);
      @(posedge clk);
      // Differs from the stored result but stays below every threshold
      adc <= {1'b1, ~a[9:0]};
      b = 1'b0;
      repeat (400) begin
         @(negedge clk);
         b = b | busy;
      end
      `CHK("shut_idle", 1'b0, b)
      rd(PTR_TEMP, 2);
      `CHK("shut_temp", {a, 5'h00}, v)
      wr(PTR_CONF, 16'h0000, 1);
      `CHK("wake_conv", 1'b1, busy)
      ov = 9'($urandom_range(16'h00f0, 16'h0010));
      hy = ov - 9'($urandom_range(8, 1));
      wr(PTR_OVER, {ov, 7'h00}, 2);
      wr(PTR_HYST, {hy, 7'h00}, 2);
      rd(PTR_OVER, 2);
      `CHK("over_rd", {ov, 7'h00}, v)
      rd(PTR_HYST, 2);
      `CHK("hyst_rd", {hy, 7'h00}, v)
      hot = {ov + 9'h001, 2'($urandom)};
      mid = {ov, 2'h3};
      cold = {hy - 9'h001, 2'h3};
      for (int q = 0; q < 4; q++) begin
         n = fault_n(q);
         wr(PTR_CONF, {11'h000, 2'(q), 3'h0}, 1);
         set_adc(hot);
         conv(n - 1);
         `CHK("alarm_early", exp_oe(1'b0), alarm_oe)
         conv(1);
         `CHK("alarm_trip", exp_oe(1'b1), alarm_oe)
         set_adc(mid);
         conv(n);
         rd(PTR_CONF, 1);
         wr(PTR_CONF, {11'h000, 2'(q), 3'h1}, 1);
         `CHK("alarm_hold", exp_oe(1'b1), alarm_oe)
         wr(PTR_CONF, {11'h000, 2'(q), 3'h0}, 1);
         set_adc(cold);
         conv(n);
         `CHK("alarm_clr", exp_oe(1'b0), alarm_oe)
      end
      wr(PTR_CONF, 16'h0004, 1);
      pol = 1'b1;
      repeat (6) @(negedge clk);
      `CHK("pol_idle", exp_oe(1'b0), alarm_oe)
      set_adc(hot);
      conv(1);
      `CHK("pol_act", exp_oe(1'b1), alarm_oe)
      set_adc(cold);
      conv(1);
      wr(PTR_CONF, 16'h0002, 1);
      pol = 1'b0;
      set_adc(hot);
      conv(1);
      `CHK("int_trip", exp_oe(1'b1), alarm_oe)
      set_adc(mid);
      conv(2);
      `CHK("int_hold", exp_oe(1'b1), alarm_oe)
      rd(PTR_CONF, 1);
      `CHK("int_conf", 16'h0002, v)
      `CHK("int_rdclr", exp_oe(1'b0), alarm_oe)
      set_adc(hot);
      conv(2);
      `CHK("int_alt", exp_oe(1'b0), alarm_oe)
      set_adc(cold);
      conv(1);
      `CHK("int_hys", exp_oe(1'b1), alarm_oe)
      wr(PTR_CONF, 16'h0003, 1);
      `CHK("int_shut", exp_oe(1'b0), alarm_oe)
      wr(PTR_CONF, 16'h0000, 1);
      for (int p = 5; p < 8; p++) begin
         rd(3'(p), 1);
         `CHK("ptr_hi", 16'h0000, v)
      end
      h.stuck(addr);
      repeat (TO - 40) @(negedge clk);
      `CHK("stuck_ack", 1'b1, sda_oe)
      repeat (80) @(negedge clk);
      `CHK("stuck_rel", 1'b0, sda_oe)
      h.seq(1'b1, 1'b0);
      rd(PTR_CONF, 1);
      `CHK("bus_back", 1'b0, nak)
      print_verdict();
   end
endmodule : tb
`default_nettype wire
